// ### src/eepj_defs.svh
// Purpose: constants for the external event priority jammer
// Assumes: 20 MHz clk, times in microseconds
// Notes: counts derived from times and the clock rate
`ifndef EEPJ_DEFS_SVH
`define EEPJ_DEFS_SVH
`define EEPJ_CLK_MHZ 20
`define EEPJ_LEVELS 9
`define EEPJ_ENC_LEVELS 8
`define EEPJ_APP_LEVELS 6
`define EEPJ_LVL_START 3'h6
`define EEPJ_LVL_PFAIL 3'h7
`define EEPJ_STAGE_STOP 8
`define EEPJ_START_PULSE_US 50
`define EEPJ_START_DEBOUNCE_US 50000
`define EEPJ_PFAIL_PULSE_US 5000
`define EEPJ_PFAIL_INTEG_US 35000
`define EEPJ_RST_FIXED 8'hC7
`define EEPJ_HALT_INSTR 8'h76
`define EEPJ_FIELD_LO 3
`define EEPJ_FIELD_HI 5
`endif

// ### src/eepj_pkg.sv
// Purpose: shared types for the external event priority jammer
// Assumes: nothing
// Notes: types only; numbers live in eepj_defs.svh
package eepj_pkg;
  typedef enum logic [1:0] {PfIdle, PfPulse, PfHold} eepj_pf_state_t;
  typedef logic [7:0] eepj_instr_t;
endpackage : eepj_pkg

// ### src/eepj_pulse_timer.sv
// Purpose: retriggerable-free one-shot timer, pulse of fixed length
// Assumes: trigger is synchronous to clk
// Notes: clear forces the output low and idles the counter
`timescale 1ns/100ps
`default_nettype none
module eepj_pulse_timer
#(
  parameter int CYCLES = 1000
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic trigger,
  output logic pulse
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] count_r;

  initial
  begin
    if (CYCLES < 1)
      $error("eepj_pulse_timer: CYCLES must be at least 1");
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_r <= '0;
    else if (clear)
      count_r <= '0;
    else if (trigger && count_r == '0)
      count_r <= W'(CYCLES);
    else if (count_r != '0)
      count_r <= count_r - 1'b1;
  end

  assign pulse = (count_r != '0);
endmodule : eepj_pulse_timer
`default_nettype wire

// ### src/external_event_priority_jammer.sv
// Purpose: nine level external event arbiter jamming restart/halt opcodes
// Assumes: cpu_sync and cpu_phase_one_clock run continuously, async pins
// Notes: rst_n stands for the power-on condition
`timescale 1ns/100ps
`default_nettype none
`include "eepj_defs.svh"
module external_event_priority_jammer
  import eepj_pkg::*;
#(
  parameter int START_DEBOUNCE_CYCLES = `EEPJ_START_DEBOUNCE_US * `EEPJ_CLK_MHZ,
  parameter int PFAIL_PULSE_CYCLES = `EEPJ_PFAIL_PULSE_US * `EEPJ_CLK_MHZ,
  parameter int PFAIL_INTEG_CYCLES = `EEPJ_PFAIL_INTEG_US * `EEPJ_CLK_MHZ
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cpu_sync,
  input wire logic cpu_phase_one_clock,
  input wire logic [5:0] app_request_n,
  input wire logic start_request_n,
  input wire logic line_present,
  input wire logic line_low_n,
  input wire logic supply_low_n,
  input wire logic stop_request_n,
  output logic [7:0] jam_instr,
  output logic ext_event_irq_n,
  output logic start_irq_n,
  output logic powerfail_stop_select_n,
  output logic auto_start_out
);
  localparam int START_PULSE_CYCLES = `EEPJ_START_PULSE_US * `EEPJ_CLK_MHZ;
  localparam int INTEG_W = $clog2(PFAIL_INTEG_CYCLES + 1);
  localparam int NPIN = 13;
  // bit positions of each pin in the synchroniser vector
  localparam int PIN_SYNC = 12;
  localparam int PIN_PHI = 11;
  localparam int PIN_APP_HI = 10;
  localparam int PIN_APP_LO = 5;
  localparam int PIN_START = 4;
  localparam int PIN_LINE = 3;
  localparam int PIN_LINE_LOW = 2;
  localparam int PIN_SUPPLY_LOW = 1;
  localparam int PIN_STOP = 0;
  // requests idle high, clocks low, so no false strobe or start after reset
  localparam logic [NPIN-1:0] PIN_IDLE = {2'b00, 6'h3F, 5'h1F};

  initial
  begin
    if (START_DEBOUNCE_CYCLES < 1)
      $error("external_event_priority_jammer: START_DEBOUNCE_CYCLES below 1");
    if (PFAIL_PULSE_CYCLES < 1)
      $error("external_event_priority_jammer: PFAIL_PULSE_CYCLES below 1");
    if (PFAIL_INTEG_CYCLES < 2)
      $error("external_event_priority_jammer: PFAIL_INTEG_CYCLES below 2");
    if (`EEPJ_ENC_LEVELS != `EEPJ_LEVELS - 1)
      $error("external_event_priority_jammer: encoder must cover all but the stop stage");
  end

  // pin synchronisers: stage one read only by stage two
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] pinMeta_r;
  logic [NPIN-1:0] pinSync_r;
  assign pinRaw = {cpu_sync, cpu_phase_one_clock, app_request_n, start_request_n,
                   line_present, line_low_n, supply_low_n, stop_request_n};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pinMeta_r <= PIN_IDLE;
    else
      pinMeta_r <= pinRaw;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pinSync_r <= PIN_IDLE;
    else
      pinSync_r <= pinMeta_r;
  end

  logic syncS, phiS, startReqS, lineS, lineLowS, supplyLowS, stopS;
  logic [5:0] appS;
  assign syncS = pinSync_r[PIN_SYNC];
  assign phiS = pinSync_r[PIN_PHI];
  assign appS = pinSync_r[PIN_APP_HI:PIN_APP_LO];
  assign startReqS = pinSync_r[PIN_START];
  assign lineS = pinSync_r[PIN_LINE];
  assign lineLowS = pinSync_r[PIN_LINE_LOW];
  assign supplyLowS = pinSync_r[PIN_SUPPLY_LOW];
  assign stopS = pinSync_r[PIN_STOP];

  // strobe on rising edge of sync AND phase one, once per time state
  logic strobeLvl, strobeLvl_r, strobe;
  assign strobeLvl = syncS & phiS;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      strobeLvl_r <= 1'b0;
    else
      strobeLvl_r <= strobeLvl;
  end
  assign strobe = strobeLvl & ~strobeLvl_r;

  // power-on start: held high while powered, one auto trigger after release
  logic autoStart_r, autoDone_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      autoStart_r <= 1'b0;
    else
      autoStart_r <= 1'b1;
  end

  // delayed copy marks the single cycle after release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      autoDone_r <= 1'b0;
    else
      autoDone_r <= autoStart_r;
  end
  assign auto_start_out = autoStart_r;
  logic autoTrigger;
  assign autoTrigger = autoStart_r & ~autoDone_r;

  // manual start: falling edge fires debounce level, its end fires start pulse
  logic startReqS_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      startReqS_r <= 1'b1;
    else
      startReqS_r <= startReqS;
  end
  logic manualFall, debounceLvl, debounceLvl_r, debounceEnd;
  assign manualFall = startReqS_r & ~startReqS;

  eepj_pulse_timer #(.CYCLES(START_DEBOUNCE_CYCLES)) u_debounce
  (
    .clk(clk),
    .rst_n(rst_n),
    .clear(1'b0),
    .trigger(manualFall),
    .pulse(debounceLvl)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      debounceLvl_r <= 1'b0;
    else
      debounceLvl_r <= debounceLvl;
  end
  // bounce is ignored until the level expires; then path joins auto start
  assign debounceEnd = debounceLvl_r & ~debounceLvl;

  logic startPulse;
  eepj_pulse_timer #(.CYCLES(START_PULSE_CYCLES)) u_start
  (
    .clk(clk),
    .rst_n(rst_n),
    .clear(1'b0),
    .trigger(autoTrigger | debounceEnd),
    .pulse(startPulse)
  );

  // line-loss integrator: restarts on each line edge, fires after timeout
  logic [INTEG_W-1:0] integ_r;
  logic lineS_r, lossFire;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lineS_r <= 1'b0;
    else
      lineS_r <= lineS;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      integ_r <= '0;
    else if (!autoStart_r)
      integ_r <= '0;
    else if (lineS != lineS_r)
      integ_r <= '0;
    else if (integ_r != INTEG_W'(PFAIL_INTEG_CYCLES))
      integ_r <= integ_r + 1'b1;
  end
  assign lossFire = (integ_r == INTEG_W'(PFAIL_INTEG_CYCLES - 1));

  logic pfailPulse;
  eepj_pulse_timer #(.CYCLES(PFAIL_PULSE_CYCLES)) u_pfail
  (
    .clk(clk),
    .rst_n(rst_n),
    .clear(~autoStart_r),
    .trigger(lossFire),
    .pulse(pfailPulse)
  );

  // request vector, index = level, active high
  logic [`EEPJ_LEVELS-1:0] request;
  assign request[`EEPJ_APP_LEVELS-1:0] = ~appS;
  assign request[`EEPJ_LVL_START] = startPulse;
  assign request[`EEPJ_LVL_PFAIL] = pfailPulse | ~lineLowS | ~supplyLowS;
  assign request[`EEPJ_STAGE_STOP] = ~stopS;

  // event latch, fully reloaded on each strobe
  logic [`EEPJ_LEVELS-1:0] eventLatch_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      eventLatch_r <= '0;
    else if (strobe)
      eventLatch_r <= request;
  end

  // priority encoder over the lower eight stages
  logic [2:0] topLevel;
  logic anyLow;
  always_comb
  begin
    topLevel = 3'h0;
    for (int i = 0; i < `EEPJ_ENC_LEVELS; i++)
    begin
      if (eventLatch_r[i])
        topLevel = 3'(i);
    end
  end
  assign anyLow = |eventLatch_r[`EEPJ_ENC_LEVELS-1:0];

  logic stopHit, pfailHit, startHit;
  assign stopHit = eventLatch_r[`EEPJ_STAGE_STOP];
  assign pfailHit = eventLatch_r[`EEPJ_LVL_PFAIL];
  assign startHit = eventLatch_r[`EEPJ_LVL_START];

  // restart opcode with level field; target is 8*n
  eepj_instr_t restartInstr;
  always_comb
  begin
    restartInstr = `EEPJ_RST_FIXED;
    restartInstr[`EEPJ_FIELD_HI:`EEPJ_FIELD_LO] = topLevel;
  end

  // outputs registered from the latch contents, one process each
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      jam_instr <= 8'h00;
    else if (stopHit)
      jam_instr <= `EEPJ_HALT_INSTR;
    else if (anyLow)
      jam_instr <= restartInstr;
    else
      jam_instr <= 8'h00;
  end

  // any of the lower eight stages raises it; stop disables the encoder
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ext_event_irq_n <= 1'b1;
    else
      ext_event_irq_n <= ~(anyLow & ~stopHit);
  end

  // follows its own stage, even while outranked
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      start_irq_n <= 1'b1;
    else
      start_irq_n <= ~startHit;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      powerfail_stop_select_n <= 1'b1;
    else
      powerfail_stop_select_n <= ~(stopHit | pfailHit);
  end
endmodule : external_event_priority_jammer
`default_nettype wire

// ### tb/eepj_cpu_model.sv
// Purpose: processor timing and fetch model
// Assumes: a time state is 80 clocks, 4 us
// Notes: strobes run free, also in wait
`timescale 1ns/100ps
`default_nettype none
module eepj_cpu_model
(
  input wire logic clk,
  input wire logic [7:0] jam,
  input wire logic extN,
  input wire logic selN,
  output logic cpuSync,
  output logic phi,
  output logic [7:0] got
);
  int n = 0;
  logic ie = 1'b0;
  always @(posedge clk)
  begin
    n <= (n + 1) % 80;
    ie <= ~ie;
    // select is mandatory, events wait for enable
    if (!selN || (!extN && ie))
      got <= jam;
  end
  assign cpuSync = n < 40;
  assign phi = n >= 10 && n < 20;
endmodule : eepj_cpu_model
`default_nettype wire

// ### tb/eepj_asserts.sv
// Purpose: output checks for the event priority jammer
// Assumes: strobe is sync and phase-one together
// Notes: codes tied to the select lines
`timescale 1ns/100ps
`default_nettype none
module eepj_asserts
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cpu_sync,
  input wire logic cpu_phase_one_clock,
  input wire logic stop_request_n,
  input wire logic [7:0] jam_instr,
  input wire logic ext_event_irq_n,
  input wire logic start_irq_n,
  input wire logic powerfail_stop_select_n,
  input wire logic auto_start_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic [2:0] q = {ext_event_irq_n, start_irq_n, powerfail_stop_select_n};
  halt_select_a: assert property (jam_instr == 8'h76 |->
    ext_event_irq_n && !powerfail_stop_select_n) else $error("halt code without select");
  restart_bits_a: assert property (jam_instr != 8'h76 && jam_instr != 8'h00 |->
    (jam_instr & 8'hC7) == 8'hC7) else $error("restart fixed bits wrong");
  app_irq_a: assert property (!ext_event_irq_n |-> (jam_instr & 8'hC7) == 8'hC7 &&
    (jam_instr[5:3] < 3'h6) == (start_irq_n && powerfail_stop_select_n))
    else $error("event irq code wrong");
  event_irq_on_a: assert property ((jam_instr & 8'hC7) == 8'hC7 |-> !ext_event_irq_n)
    else $error("restart code without event irq");
  start_code_a: assert property (!start_irq_n && powerfail_stop_select_n |->
    jam_instr == 8'hF7 && !ext_event_irq_n) else $error("start irq code wrong");
  select_code_a: assert property (!powerfail_stop_select_n |->
    jam_instr inside {8'hFF, 8'h76}) else $error("select code wrong");
  idle_zero_a: assert property (q == 3'b111 |-> jam_instr == 8'h00)
    else $error("idle code not zero");
  power_hold_a: assert property (auto_start_out |=> auto_start_out)
    else $error("auto start fell");
  stop_wins_a: assert property ($rose(cpu_sync && cpu_phase_one_clock) &&
    !stop_request_n && $past(!stop_request_n, 4) |-> ##[2:6] jam_instr == 8'h76)
    else $error("stop not jammed");
  cover property (jam_instr == 8'h76);
  cover property (!start_irq_n);
  cover property (!ext_event_irq_n);
endmodule : eepj_asserts
bind external_event_priority_jammer eepj_asserts i_chk (.clk(clk), .rst_n(rst_n),
  .cpu_sync(cpu_sync), .cpu_phase_one_clock(cpu_phase_one_clock),
  .stop_request_n(stop_request_n), .jam_instr(jam_instr),
  .ext_event_irq_n(ext_event_irq_n), .start_irq_n(start_irq_n),
  .powerfail_stop_select_n(powerfail_stop_select_n), .auto_start_out(auto_start_out));
`default_nettype wire

// ### tb/test_external_event_priority_jammer.sv
// Purpose: self-checking bench for the event priority jammer
// Assumes: shortened debounce and power-fail counts
// Notes: line signal toggles every 10 clocks while on
`timescale 1ns/100ps
`default_nettype none
module test_external_event_priority_jammer;
  import eepj_pkg::*;
  logic clk = 0, rst_n = 0, cs, ph, lp = 0, lineOn = 1;
  logic stN = 1, alN = 1, dlN = 1, spN = 1, en, sn, fn, au;
  logic [5:0] ap = 6'h3F;
  eepj_instr_t jam, got;
  int n_fail = 0, checks_done = 0, seed = 32'h86E5;
  initial forever #25 clk = ~clk;
  always
  begin
    repeat (10) @(posedge clk);
    #2;
    if (lineOn)
      lp = ~lp;
  end
  external_event_priority_jammer #(.START_DEBOUNCE_CYCLES(20), .PFAIL_PULSE_CYCLES(200),
    .PFAIL_INTEG_CYCLES(40)) i_dut (.clk(clk), .rst_n(rst_n), .cpu_sync(cs),
    .cpu_phase_one_clock(ph), .app_request_n(ap), .start_request_n(stN), .line_present(lp),
    .line_low_n(alN), .supply_low_n(dlN), .stop_request_n(spN), .jam_instr(jam),
    .ext_event_irq_n(en), .start_irq_n(sn), .powerfail_stop_select_n(fn), .auto_start_out(au));
  eepj_cpu_model i_cpu (.clk(clk), .jam(jam), .extN(en), .selN(fn), .cpuSync(cs), .phi(ph),
    .got(got));
  task automatic check(input logic [7:0] seen, want);
    checks_done++;
    if (seen !== want)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  // stop, power fail and start outrank the held app lines
  function automatic eepj_instr_t expCode(input logic st, pf);
    if (!spN)
      return 8'h76;
    if (pf || !alN || !dlN)
      return 8'hFF;
    if (st)
      return 8'hF7;
    for (int i = 5; i >= 0; i--)
      if (!ap[i])
        return 8'hC7 | {2'h0, 3'(i), 3'h0};
    return 8'h00;
  endfunction : expCode
  task automatic expectCode(input logic st, pf, input int lim);
    eepj_instr_t e;
    int i;
    e = expCode(st, pf);
    for (i = 0; i < lim && jam !== e; i++)
    begin
      @(posedge clk);
      #2;
    end
    if (jam !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t timeout", $time);
      close_out();
    end
    check(jam, e);
    check({5'h0, en, sn, fn}, {5'h0, (e == 8'h00 || e == 8'h76), !st,
      (e != 8'hFF && e != 8'h76)});
  endtask : expectCode
  initial
  begin
    repeat (3) @(posedge clk);
    #2 rst_n = 1;
    repeat (2) @(posedge clk);
    #2 check({7'h0, au}, 8'h01);
    expectCode(1, 0, 300);
    expectCode(0, 0, 2000);
    $display("auto start done");
    for (int i = 0; i < 14; i++)
    begin
      ap = i < 6 ? ~((6'h01 << i) | 6'h01) : 6'($random(seed));
      expectCode(0, 0, 300);
    end
    $display("levels done");
    ap = 6'h00;
    alN = 0;
    expectCode(0, 0, 300);
    @(posedge clk);
    #2 check(got, expCode(0, 0));
    alN = 1;
    expectCode(0, 0, 300);
    dlN = 0;
    expectCode(0, 0, 300);
    spN = 0;
    expectCode(0, 0, 300);
    spN = 1;
    dlN = 1;
    expectCode(0, 0, 300);
    $display("power fail and stop done");
    stN = 0;
    repeat (30) @(posedge clk);
    #2 stN = 1;
    expectCode(1, 0, 1500);
    spN = 0;
    expectCode(1, 0, 300);
    spN = 1;
    expectCode(0, 0, 1500);
    $display("manual start done");
    lineOn = 0;
    expectCode(0, 1, 600);
    expectCode(0, 0, 600);
    lineOn = 1;
    $display("line loss done");
    close_out();
  end
endmodule : test_external_event_priority_jammer
`default_nettype wire
